// [include/kwu_map.svh]
// Constants of the key-on wakeup block: offsets, fields, reset values, timing
// How it works
// - STOP ends from the release pin or from any of four key inputs.
// - Each key input has its own enable bit.
// - Enable register at 0x0031 holds keys five down to two in bits 7..4.
// - After reset all key enables are zero; low four bits undefined.
// - A low level on an enabled key input ends STOP.
// - Pin releases on high level or rising edge; keys only in level mode.
// - Release condition present at stop entry skips STOP, starts warm-up.
// - Release pin has no enable, always acts; wire it when keys wake.
// - Key levels are readable through a port data register.
`ifndef KWU_MAP_SVH
`define KWU_MAP_SVH

`define KWU_ADDR_W 16
`define KWU_DATA_W 8

`define KWU_OFF_SYSCTL 16'h0030
`define KWU_OFF_ENABLE 16'h0031
`define KWU_OFF_PORT 16'h0032
`define KWU_OFF_STATUS 16'h0033
`define KWU_OFF_MASK 16'h0034
`define KWU_OFF_STATE 16'h0035

`define KWU_EN_LSB 4
`define KWU_EN_MSB 7
`define KWU_EN_RESET 4'h0
`define KWU_RELM_BIT 0
`define KWU_RELM_RESET 1'b0
`define KWU_PORT_PIN_BIT 0

`define KWU_ST_WAKE 0
`define KWU_ST_ABORT 1
`define KWU_ST_DONE 2
`define KWU_EVT_W 3
`define KWU_MASK_RESET 3'h0

`define KWU_WARM_W 8
`define KWU_WARM_CYCLES 8'h10

`endif

// [include/kwu_pkg.sv]
// Types of the key-on wakeup block
package kwu_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } kwu_bus_t;

  typedef struct packed {
    logic pin;
    logic [3:0] keys;
  } kwu_pins_t;

  typedef enum logic [2:0] {
    KWU_RUN = 3'h1,
    KWU_STOP = 3'h2,
    KWU_WARM = 3'h4
  } kwu_state_t;

endpackage : kwu_pkg

// [core/kwu_sync.sv]
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module kwu_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Each bit resets to the idle level of its pin, so no false event follows reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          stage1_reg <= RESET_VAL[i];
          stage2_reg <= RESET_VAL[i];
        end else begin
          stage1_reg <= async_in[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign sync_out[i] = stage2_reg;
    end
  endgenerate

endmodule : kwu_sync

// [core/kwu_warmup.sv]
// Warm-up counter started after a release, ending in a one-cycle done pulse
`timescale 1ns/10ps
`include "kwu_map.svh"
module kwu_warmup (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  logic [`KWU_WARM_W-1:0] count_reg;
  logic [`KWU_WARM_W-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  wire last_w = busy_reg && (count_reg == `KWU_WARM_CYCLES - 8'h01);

  assign count_next = start_in ? 8'h00 : (busy_reg ? count_reg + 8'h01 : count_reg);
  assign busy_next = start_in | (busy_reg & ~last_w);
  assign done_next = last_w & ~start_in;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;

endmodule : kwu_warmup

// [core/kwu_core.sv]
// Key-on wakeup: STOP entry, release detection, warm-up and register file
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "kwu_map.svh"
module kwu_core
  import kwu_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic stop_entry_in,
  input wire logic release_pin_in,
  input wire logic key_wake_input_2_in,
  input wire logic key_wake_input_3_in,
  input wire logic key_wake_input_4_in,
  input wire logic key_wake_input_5_in,
  output logic release_req_out,
  output logic stop_mode_out,
  output logic warmup_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Address decode helper
  // ---------------------------------------------------------------

  function automatic logic kwu_hit(input logic [15:0] addr, input logic [15:0] off);
    kwu_hit = (addr == off);
  endfunction : kwu_hit

  // ---------------------------------------------------------------
  // Bus and pin bundles
  // ---------------------------------------------------------------

  kwu_bus_t bus;
  kwu_pins_t pins_raw;
  kwu_pins_t pins_sync;
  logic [4:0] pins_sync_vec;

  assign bus.addr = reg_addr_in;
  assign bus.wdata = reg_wdata_in;
  assign bus.wr = reg_wr_in;
  assign bus.rd = reg_rd_in;

  // Index 0 is key input two, index 3 is key input five
  assign pins_raw.pin = release_pin_in;
  assign pins_raw.keys = {key_wake_input_5_in, key_wake_input_4_in,
                          key_wake_input_3_in, key_wake_input_2_in};

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------

  // Idle levels: release pin low, keys high
  kwu_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h0f)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(pins_raw),
    .sync_out(pins_sync_vec)
  );

  assign pins_sync = pins_sync_vec;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------

  logic [3:0] key_wake_enable_reg;
  logic [3:0] key_wake_enable_next;
  logic release_mode_level_reg;
  logic release_mode_level_next;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------

  wire wr_sysctl_w = bus.wr && kwu_hit(bus.addr, `KWU_OFF_SYSCTL);
  wire wr_enable_w = bus.wr && kwu_hit(bus.addr, `KWU_OFF_ENABLE);
  wire wr_status_w = bus.wr && kwu_hit(bus.addr, `KWU_OFF_STATUS);
  wire wr_mask_w = bus.wr && kwu_hit(bus.addr, `KWU_OFF_MASK);

  // Each key gets its own enable, keys five..two in bits 7..4
  assign key_wake_enable_next = wr_enable_w ?
      bus.wdata[`KWU_EN_MSB:`KWU_EN_LSB] : key_wake_enable_reg;

  assign release_mode_level_next = wr_sysctl_w ?
      bus.wdata[`KWU_RELM_BIT] : release_mode_level_reg;

  assign mask_next = wr_mask_w ? bus.wdata[2:0] : mask_reg;

  // ---------------------------------------------------------------
  // Release qualification
  // ---------------------------------------------------------------

  kwu_state_t state_reg;
  kwu_state_t state_next;
  logic edge_arm_reg;
  logic edge_arm_next;

  // Edge mode: pin must be seen low during STOP before a high counts,
  // which makes a rising edge out of pure levels with the clocked edge_arm_reg flag
  assign edge_arm_next = (state_reg == KWU_STOP) && (edge_arm_reg || !pins_sync.pin);

  // Pin has no enable and is always a source
  wire pin_cond_raw_w = release_mode_level_reg ? pins_raw.pin
                                               : (pins_raw.pin && edge_arm_reg);

  // Keys count only when enabled, only low, only in level mode
  wire key_cond_raw_w = release_mode_level_reg &&
                        (|(key_wake_enable_reg & ~pins_raw.keys));

  // Unclocked request to the oscillator control while clocks stand still
  assign release_req_out = pin_cond_raw_w || key_cond_raw_w;

  // Clocked copy of the same request built from synchronised pins
  wire pin_cond_w = release_mode_level_reg ? pins_sync.pin
                                           : (pins_sync.pin && edge_arm_reg);
  wire key_cond_w = release_mode_level_reg &&
                    (|(key_wake_enable_reg & ~pins_sync.keys));
  wire release_w = pin_cond_w || key_cond_w;

  // Entry is refused while the pin is high or an enabled key is low
  wire entry_block_w = pins_sync.pin || (|(key_wake_enable_reg & ~pins_sync.keys));

  // ---------------------------------------------------------------
  // Warm-up counter
  // ---------------------------------------------------------------

  logic warm_start;
  logic warm_busy;
  logic warm_done;

  kwu_warmup u_warmup (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(warm_start),
    .busy_out(warm_busy),
    .done_out(warm_done)
  );

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------

  logic evt_wake;
  logic evt_abort;

  always_comb begin
    state_next = state_reg;
    evt_wake = 1'b0;
    evt_abort = 1'b0;
    case (state_reg)
      KWU_RUN: begin
        if (stop_entry_in) begin
          if (entry_block_w) begin
            state_next = KWU_WARM;
            evt_abort = 1'b1;
          end else begin
            state_next = KWU_STOP;
          end
        end
      end
      KWU_STOP: begin
        if (release_w) begin
          state_next = KWU_WARM;
          evt_wake = 1'b1;
        end
      end
      KWU_WARM: begin
        if (warm_done) begin
          state_next = KWU_RUN;
        end
      end
      default: begin
        state_next = KWU_RUN;
      end
    endcase
  end

  assign warm_start = (state_next == KWU_WARM) && (state_reg != KWU_WARM);

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------

  logic [2:0] evt_vec;

  assign evt_vec[`KWU_ST_WAKE] = evt_wake;
  assign evt_vec[`KWU_ST_ABORT] = evt_abort;
  assign evt_vec[`KWU_ST_DONE] = warm_done;

  // Writing one clears a bit; a new event in the same cycle wins
  wire [2:0] status_clr_w = wr_status_w ? bus.wdata[2:0] : 3'h0;
  assign status_next = (status_reg & ~status_clr_w) | evt_vec;

  assign irq_out = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------

  wire rd_sysctl_w = bus.rd && kwu_hit(bus.addr, `KWU_OFF_SYSCTL);
  wire rd_port_w = bus.rd && kwu_hit(bus.addr, `KWU_OFF_PORT);
  wire rd_status_w = bus.rd && kwu_hit(bus.addr, `KWU_OFF_STATUS);
  wire rd_mask_w = bus.rd && kwu_hit(bus.addr, `KWU_OFF_MASK);
  wire rd_state_w = bus.rd && kwu_hit(bus.addr, `KWU_OFF_STATE);

  // Port view of the key levels, independent of the wakeup detector
  wire [7:0] port_view_w = {pins_sync.keys, 3'h0, pins_sync.pin};

  // Enable register is write-only and reads as zero like any unmapped address
  always_comb begin
    if (rd_sysctl_w) begin
      rdata_next = {7'h00, release_mode_level_reg};
    end else if (rd_port_w) begin
      rdata_next = port_view_w;
    end else if (rd_status_w) begin
      rdata_next = {5'h00, status_reg};
    end else if (rd_mask_w) begin
      rdata_next = {5'h00, mask_reg};
    end else if (rd_state_w) begin
      rdata_next = {5'h00, state_reg};
    end else begin
      rdata_next = 8'h00;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      key_wake_enable_reg <= `KWU_EN_RESET;
      release_mode_level_reg <= `KWU_RELM_RESET;
      mask_reg <= `KWU_MASK_RESET;
    end else begin
      key_wake_enable_reg <= key_wake_enable_next;
      release_mode_level_reg <= release_mode_level_next;
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= KWU_RUN;
      edge_arm_reg <= 1'b0;
      status_reg <= 3'h0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      edge_arm_reg <= edge_arm_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Mode outputs
  // ---------------------------------------------------------------

  assign stop_mode_out = (state_reg == KWU_STOP);
  assign warmup_out = warm_busy;

endmodule : kwu_core

// [verification/kwu_sva.sv]
// Port checker for the key-on wakeup core
`timescale 1ns/10ps
`include "kwu_map.svh"
module kwu_sva (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic stop_entry_in,
  input wire logic release_pin_in,
  input wire logic key_wake_input_2_in,
  input wire logic key_wake_input_3_in,
  input wire logic key_wake_input_4_in,
  input wire logic key_wake_input_5_in,
  input wire logic release_req_out,
  input wire logic stop_mode_out,
  input wire logic warmup_out,
  input wire logic irq_out
);
  logic lvl_reg;
  logic [3:0] en_reg;
  logic [7:0] wcnt_reg;
  wire logic [3:0] keys_w = {key_wake_input_5_in, key_wake_input_4_in,
    key_wake_input_3_in, key_wake_input_2_in};
  wire logic kany_w = |(en_reg & ~keys_w);
  wire logic klow_w = lvl_reg & kany_w;
  wire logic run_w = !stop_mode_out && !warmup_out;
  // ----------------------------------------
  // Shadow of mode and enables from bus writes, and warm-up cycle count
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lvl_reg <= 1'b0;
      en_reg <= 4'h0;
      wcnt_reg <= 8'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == `KWU_OFF_SYSCTL) begin
        lvl_reg <= reg_wdata_in[`KWU_RELM_BIT];
      end
      if (reg_wr_in && reg_addr_in == `KWU_OFF_ENABLE) begin
        en_reg <= reg_wdata_in[7:4];
      end
      wcnt_reg <= warmup_out ? wcnt_reg + 8'h01 : 8'h00;
    end
  end
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  chk_key_level_req: assert property (klow_w |-> release_req_out)
    else $error("enabled low key gives no request");
  chk_pin_level_req: assert property (lvl_reg && release_pin_in |-> release_req_out)
    else $error("high release pin gives no request");
  chk_req_no_cause: assert property (!release_pin_in && !klow_w |-> !release_req_out)
    else $error("request without a cause");
  chk_stop_from_entry: assert property ($rose(stop_mode_out) |-> $past(stop_entry_in))
    else $error("stop mode without entry");
  chk_stop_entered: assert property (stop_entry_in && run_w
    && !release_pin_in && !kany_w |=> stop_mode_out)
    else $error("entry did not reach stop mode");
  chk_entry_refused: assert property (stop_entry_in && run_w
    && (release_pin_in || kany_w) |=> warmup_out && !stop_mode_out)
    else $error("entry with release pending not refused");
  chk_wake_in_time: assert property (stop_mode_out && release_req_out
    |-> ##[1:5] !stop_mode_out)
    else $error("stop mode not left after request");
  chk_warm_length: assert property ($fell(warmup_out) |-> wcnt_reg == `KWU_WARM_CYCLES)
    else $error("warm-up length wrong");
  chk_enable_write_only: assert property (reg_rd_in && reg_addr_in == `KWU_OFF_ENABLE
    |=> reg_rdata_out == 8'h00)
    else $error("enable register readable");
endmodule : kwu_sva
bind kwu_core kwu_sva kwu_sva_i (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .stop_entry_in, .release_pin_in,
  .key_wake_input_2_in, .key_wake_input_3_in, .key_wake_input_4_in, .key_wake_input_5_in,
  .release_req_out, .stop_mode_out, .warmup_out, .irq_out);

// [verification/kwu_keys_model.sv]
// Key switches and release pin on the far side of the wakeup core
`timescale 1ns/10ps
module kwu_keys_model (
  input wire logic [3:0] press_in,
  input wire logic pin_high_in,
  output logic [3:0] keys_out,
  output logic pin_out
);
  // Keys are pulled up and pull to ground while pressed
  assign keys_out = ~press_in;
  // Pin is held low unless a pin wakeup is wanted
  assign pin_out = pin_high_in;
endmodule : kwu_keys_model

// [verification/key_wakeup_release_tb_top.sv]
// Self-checking bench for the key-on wakeup core
`timescale 1ns/10ps
`include "kwu_map.svh"
module key_wakeup_release_tb_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic stop_entry_in = 1'b0;
  logic [3:0] press = 4'h0;
  logic pin_high = 1'b0;
  logic [3:0] keys;
  logic pin;
  logic [7:0] reg_rdata_out;
  logic release_req_out;
  logic stop_mode_out;
  logic warmup_out;
  logic irq_out;
  int n_fail = 0;
  int checked = 0;
  always #5 clk_in = ~clk_in;
  kwu_keys_model kwu_keys_model_i (.press_in(press), .pin_high_in(pin_high), .keys_out(keys),
    .pin_out(pin));
  kwu_core kwu_core_i (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .stop_entry_in, .release_pin_in(pin),
    .key_wake_input_2_in(keys[0]), .key_wake_input_3_in(keys[1]),
    .key_wake_input_4_in(keys[2]), .key_wake_input_5_in(keys[3]), .release_req_out,
    .stop_mode_out, .warmup_out, .irq_out);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, reg_rdata_out, e);
  endtask : rd_reg
  task automatic enter_stop(input logic e);
    @(posedge clk_in);
    stop_entry_in <= 1'b1;
    @(posedge clk_in);
    stop_entry_in <= 1'b0;
    #1 chk("stop_mode", {7'h00, stop_mode_out}, {7'h00, e});
  endtask : enter_stop
  task automatic wake_done(input string nm);
    int k;
    for (k = 0; k < 10 && warmup_out !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk(nm, {6'h00, stop_mode_out, warmup_out}, 8'h01);
    for (k = 0; k < 40 && warmup_out === 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk("warm_len", k[7:0], `KWU_WARM_CYCLES);
  endtask : wake_done
  task automatic t_regs();
    rd_reg("enable", `KWU_OFF_ENABLE, 8'h00);
    wr_reg(`KWU_OFF_ENABLE, 8'hf0);
    rd_reg("enable_wo", `KWU_OFF_ENABLE, 8'h00);
    rd_reg("sysctl", `KWU_OFF_SYSCTL, 8'h00);
    rd_reg("state", `KWU_OFF_STATE, 8'h01);
    rd_reg("unmapped", 16'h0040, 8'h00);
    rd_reg("port", `KWU_OFF_PORT, 8'hf0);
    @(posedge clk_in);
    press <= 4'h5;
    repeat (3) @(posedge clk_in);
    rd_reg("port_keys", `KWU_OFF_PORT, 8'ha0);
    @(posedge clk_in);
    press <= 4'h0;
    wr_reg(`KWU_OFF_ENABLE, 8'h00);
  endtask : t_regs
  task automatic t_keys();
    int i;
    wr_reg(`KWU_OFF_SYSCTL, 8'h01);
    wr_reg(`KWU_OFF_MASK, 8'h07);
    rd_reg("sysctl_lvl", `KWU_OFF_SYSCTL, 8'h01);
    rd_reg("mask", `KWU_OFF_MASK, 8'h07);
    for (i = 0; i < 4; i++) begin
      wr_reg(`KWU_OFF_ENABLE, 8'h10 << i);
      rd_reg("port_pre", `KWU_OFF_PORT, 8'hf0);
      enter_stop(1'b1);
      rd_reg("state_stop", `KWU_OFF_STATE, 8'h02);
      @(posedge clk_in);
      press <= 4'h1 << ((i + 1) % 4);
      repeat (6) @(posedge clk_in);
      #1 chk("blocked", {6'h00, release_req_out, stop_mode_out}, 8'h01);
      @(posedge clk_in);
      press <= 4'h1 << i;
      #1 chk("req_key", {7'h00, release_req_out}, 8'h01);
      wake_done("key_wake");
      @(posedge clk_in);
      press <= 4'h0;
      rd_reg("status", `KWU_OFF_STATUS, 8'h05);
      chk("irq_on", {7'h00, irq_out}, 8'h01);
      wr_reg(`KWU_OFF_STATUS, 8'h07);
      #1 chk("irq_off", {7'h00, irq_out}, 8'h00);
    end
    enter_stop(1'b1);
    @(posedge clk_in);
    pin_high <= 1'b1;
    #1 chk("req_pin", {7'h00, release_req_out}, 8'h01);
    wake_done("pin_level");
    @(posedge clk_in);
    pin_high <= 1'b0;
    rd_reg("status_lvl", `KWU_OFF_STATUS, 8'h05);
    wr_reg(`KWU_OFF_STATUS, 8'h07);
  endtask : t_keys
  task automatic t_refuse();
    wr_reg(`KWU_OFF_MASK, 8'h00);
    wr_reg(`KWU_OFF_ENABLE, 8'h10);
    @(posedge clk_in);
    press <= 4'h1;
    repeat (3) @(posedge clk_in);
    enter_stop(1'b0);
    wake_done("refused");
    @(posedge clk_in);
    press <= 4'h0;
    rd_reg("status_ref", `KWU_OFF_STATUS, 8'h06);
    chk("irq_masked", {7'h00, irq_out}, 8'h00);
    wr_reg(`KWU_OFF_STATUS, 8'hff);
    rd_reg("status_clr", `KWU_OFF_STATUS, 8'h00);
  endtask : t_refuse
  task automatic t_edge();
    wr_reg(`KWU_OFF_SYSCTL, 8'h00);
    enter_stop(1'b1);
    repeat (4) @(posedge clk_in);
    pin_high <= 1'b1;
    #1 chk("req_edge", {7'h00, release_req_out}, 8'h01);
    wake_done("pin_edge");
    @(posedge clk_in);
    pin_high <= 1'b0;
    rd_reg("status_pin", `KWU_OFF_STATUS, 8'h05);
  endtask : t_edge
  task automatic end_of_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_keys();
    t_refuse();
    t_edge();
    end_of_test();
  end
  // Tests need well under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule : key_wakeup_release_tb_top
